//--- rtl/dsc_pkg.sv
// constants, register map and types of the dual-channel conversion port
// assumes a 125 MHz system clock and 32-bit AHB-Lite register access
package dsc_pkg;
   // data and timing
   localparam int DATA_W = 16;
   localparam int CLK_PERIOD_NS = 8;
   localparam int CLK_MHZ = 125;
   localparam int IMPULSE_RATE_KSPS = 888;
   localparam int CONV_TIME_NS = 400;
   localparam int SER_BIT_NS = 40;
   localparam int CNT_W = 8;
   // shortest sample period rounds down, so free run may be slightly faster
   localparam int SAMPLE_CYC = (CLK_MHZ * 1000) / IMPULSE_RATE_KSPS;
   localparam int CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACQ_CYC = SAMPLE_CYC - 2 * CONV_CYC;
   localparam int SER_CYC = (SER_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYC - 1);
   localparam logic [CNT_W-1:0] ACQ_LAST = CNT_W'(ACQ_CYC - 1);
   localparam logic [CNT_W-1:0] SER_LAST = CNT_W'(SER_CYC - 1);
   localparam logic [5:0] SER_BITS = 6'h20;
   localparam int SER_OUT_PIN = 8;
   // register map, byte addresses
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] REG_RESULT = 8'h08;
   localparam logic [ADDR_W-1:0] REG_COUNT = 8'h0c;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam int CTRL_IMPULSE = 0;
   localparam int CTRL_HOLD = 1;
   localparam int ST_BUSY = 0;
   localparam int ST_CONVERTING = 1;
   localparam int ST_LOW_POWER = 2;
   localparam int ST_BUF_FULL = 3;
   localparam int ST_STATE = 8;
   // bus encodings
   localparam logic [1:0] HTRANS_IDLE = 2'h0;
   localparam logic HRESP_OKAY = 1'h0;
   typedef enum logic [3:0] {
      DSC_IDLE = 4'h1,
      DSC_CONV_A = 4'h2,
      DSC_CONV_B = 4'h4,
      DSC_ACQ = 4'h8
   } dsc_state_t;
   typedef struct packed {
      logic chan_b;
      logic [DATA_W-1:0] code;
   } dsc_word_t;
endpackage

//--- rtl/dsc_word_if.sv
// carrier between the conversion sequencer and its result buffer
// assumes both ends sit on the same clock
`timescale 1ns/100ps
interface dsc_word_if;
   logic in_valid;
   logic in_ready;
   dsc_pkg::dsc_word_t in_data;
   logic out_valid;
   logic out_ready;
   dsc_pkg::dsc_word_t out_data;
   modport store (input in_valid, input in_data, input out_ready,
      output in_ready, output out_valid, output out_data);
   modport user (output in_valid, output in_data, output out_ready,
      input in_ready, input out_valid, input out_data);
endinterface

//--- rtl/dsc_pair_buffer.sv
// small result queue with valid and ready on both sides
// assumes synchronous active-low reset and a common clock enable
`timescale 1ns/100ps
module dsc_pair_buffer #(
   parameter int DEPTH = 2,
   parameter int WIDTH = $bits(dsc_pkg::dsc_word_t)
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   dsc_word_if.store port
);
   import dsc_pkg::*;
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
   localparam int CNT_BITS = $clog2(DEPTH + 1);
   localparam logic [CNT_BITS-1:0] CNT_FULL = CNT_BITS'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   logic [CNT_BITS-1:0] count;
   wire push = port.in_valid & port.in_ready;
   wire pop = port.out_valid & port.out_ready;

   // honest flags straight from the fill count
   assign port.in_ready = (count != CNT_FULL);
   assign port.out_valid = (count != '0);
   assign port.out_data = dsc_word_t'(mem[rd_ptr]);

   // storage and pointers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else if (ce) begin
         if (push) begin
            mem[wr_ptr] <= port.in_data;
            wr_ptr <= (wr_ptr == PTR_LAST) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == PTR_LAST) ? '0 : rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule

//--- rtl/dsc_conv_port.sv
// conversion sequencer and parallel read port of a two-channel converter
// assumes pins arrive unsynchronised and AHB-Lite runs on SYS_CLK
// Function
// (RULE1) a falling start strobe begins a conversion nothing can restart
// (RULE2) the start strobe ignores select and read enable
// (RULE3) impulse mode with start held low relaunches after self-timed acquire
// (RULE4) host must pull start low once after power-up
// (RULE5) select or read enable high puts all outputs in high impedance; code floats only the data pins
// (RULE6) channel pick picks parallel channel or first serial channel
// (RULE7) converter reset high aborts conversion and releases the bus
// (RULE8) style select low gives parallel port; serial shares data pins
// (RULE9) serial output sits on a data bus pin, no pin of its own
// (RULE10) select and read tied low drive the latest result continuously
// (RULE11) results readable in acquisition, other channel or next conversion
// (RULE12) host should read during the first half of a conversion phase
// (RULE13) impulse mode drops power after each conversion phase; code drops it only after the second channel's phase
// (RULE14) read port keeps working during low-power acquisition
// (RULE15) pair select low takes first pair, high second; stable in acquire
// (RULE16) first channel always converts before the second
// (RULE17) pick high shows first channel result, low shows second
// (RULE18) busy stands from conversion start until second result is done
`timescale 1ns/100ps
module dsc_conv_port (
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   input wire logic CLK_EN,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic CONVERT_START_N,
   input wire logic CHIP_SELECT_N,
   input wire logic READ_ENABLE_N,
   input wire logic CHANNEL_PICK,
   input wire logic PORT_STYLE_SELECT,
   input wire logic INPUT_PAIR_SELECT,
   input wire logic POWER_DOWN_INPUT,
   input wire logic CONVERTER_RESET,
   input wire logic [1:0][dsc_pkg::DATA_W-1:0] FIRST_CHANNEL_INPUT,
   input wire logic [1:0][dsc_pkg::DATA_W-1:0] SECOND_CHANNEL_INPUT,
   output logic BUSY,
   output logic CHANNEL_CONVERTING,
   output logic LOW_POWER,
   output logic [dsc_pkg::DATA_W-1:0] DATA_OUT,
   output logic [dsc_pkg::DATA_W-1:0] DATA_OE_N
);
   import dsc_pkg::*;
   localparam int PIN_N = 7 + 4 * DATA_W;

   // pin synchronisers, two flops per bit
   wire [PIN_N-1:0] pin_raw = {CONVERT_START_N, CHIP_SELECT_N,
      READ_ENABLE_N, CHANNEL_PICK, PORT_STYLE_SELECT, INPUT_PAIR_SELECT,
      POWER_DOWN_INPUT, FIRST_CHANNEL_INPUT, SECOND_CHANNEL_INPUT};
   logic [PIN_N-1:0] sync_a;
   logic [PIN_N-1:0] sync_b;
   genvar gi;
   generate
      for (gi = 0; gi < PIN_N; gi++) begin : g_sync
         always_ff @(posedge SYS_CLK) begin
            if (!RESET_N) begin
               sync_a[gi] <= 1'b1;
               sync_b[gi] <= 1'b1;
            end else if (CLK_EN) begin
               sync_a[gi] <= pin_raw[gi];
               sync_b[gi] <= sync_a[gi];
            end
         end
      end
   endgenerate
   logic conv_reset_a;
   logic conv_reset;

   // named views of the synchronised pins
   wire start_n = sync_b[PIN_N-1];
   wire sel_n = sync_b[PIN_N-2];
   wire rd_n = sync_b[PIN_N-3];
   wire pick_a = sync_b[PIN_N-4];
   wire serial_style = sync_b[PIN_N-5];
   wire pair_sel = sync_b[PIN_N-6];
   wire power_down = sync_b[PIN_N-7];
   wire [1:0][DATA_W-1:0] first_in = sync_b[4*DATA_W-1:2*DATA_W];
   wire [1:0][DATA_W-1:0] second_in = sync_b[2*DATA_W-1:0];

   // reset pin kept apart so it can idle low after reset
   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         conv_reset_a <= 1'b0;
         conv_reset <= 1'b0;
      end else if (CLK_EN) begin
         conv_reset_a <= CONVERTER_RESET;
         conv_reset <= conv_reset_a;
      end
   end

   // software control and observed state
   logic [1:0] ctrl;
   logic [31:0] conv_count;
   dsc_state_t state;
   dsc_state_t next_state;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic start_prev;
   logic start_pend;
   logic [DATA_W-1:0] samp_a;
   logic [DATA_W-1:0] samp_b;
   logic [DATA_W-1:0] result_a;
   logic [DATA_W-1:0] result_b;
   wire impulse = ctrl[CTRL_IMPULSE];
   wire hold_results = ctrl[CTRL_HOLD];

   dsc_word_if wq ();
   dsc_pair_buffer #(.DEPTH(2)) u_buf (
      .clk(SYS_CLK),
      .rst_n(RESET_N),
      .ce(CLK_EN),
      .port(wq.store)
   );

   // start detection, read-port pins play no part here
   wire start_fall = start_prev & ~start_n; // RULE2
   wire in_conv = (state == DSC_CONV_A) || (state == DSC_CONV_B);
   wire cnt_done = (cnt == '0);
   wire can_start = start_pend & ~power_down & wq.in_ready;
   wire auto_go = impulse & ~start_n & ~power_down; // RULE3
   wire pushing = in_conv & cnt_done & ~conv_reset;
   wire pushed = pushing & wq.in_ready;
   wire pair_done = pushed & (state == DSC_CONV_B);

   // each channel result enters the buffer when its phase ends
   assign wq.in_valid = pushing;
   assign wq.in_data = '{chan_b: (state == DSC_CONV_B),
      code: (state == DSC_CONV_B) ? samp_b : samp_a};
   // drain stalls while software holds the presented results
   assign wq.out_ready = ~hold_results;
   wire popped = wq.out_valid & ~hold_results;

   // conversion sequencer
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      unique case (state)
         DSC_IDLE: begin
            if (can_start) begin // RULE1
               next_state = DSC_CONV_A;
               next_cnt = CONV_LAST;
            end else if (auto_go && !start_fall) begin // RULE1 RULE3
               next_state = DSC_ACQ;
               next_cnt = ACQ_LAST;
            end
         end
         DSC_CONV_A: begin
            if (!cnt_done) begin
               next_cnt = cnt - 1'b1;
            end else if (pushed) begin // RULE16
               next_state = DSC_CONV_B;
               next_cnt = CONV_LAST;
            end
         end
         DSC_CONV_B: begin
            if (!cnt_done) begin
               next_cnt = cnt - 1'b1;
            end else if (pushed && auto_go) begin // RULE3
               next_state = DSC_ACQ;
               next_cnt = ACQ_LAST;
            end else if (pushed) begin
               next_state = DSC_IDLE;
            end
         end
         DSC_ACQ: begin
            if (!cnt_done) begin
               next_cnt = cnt - 1'b1;
            end else if (auto_go && wq.in_ready) begin // RULE3
               next_state = DSC_CONV_A;
               next_cnt = CONV_LAST;
            end else if (!auto_go) begin
               next_state = DSC_IDLE;
            end
         end
      endcase
      if (conv_reset) begin // RULE7
         next_state = DSC_IDLE;
         next_cnt = '0;
      end
   end

   wire launching = (next_state == DSC_CONV_A) && !in_conv;

   // sequencer state and sampling, a strobe mid-conversion is ignored
   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         state <= DSC_IDLE;
         cnt <= '0;
         start_prev <= 1'b1;
         start_pend <= 1'b0;
      end else if (CLK_EN) begin
         state <= next_state;
         cnt <= next_cnt;
         start_prev <= start_n;
         if (start_fall && !in_conv && !conv_reset) begin // RULE1
            start_pend <= 1'b1;
         end else if (launching || conv_reset) begin
            start_pend <= 1'b0;
         end
      end
   end

   // both channels of the chosen pair are held at the same instant
   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         samp_a <= '0;
         samp_b <= '0;
      end else if (CLK_EN && launching) begin
         samp_a <= first_in[pair_sel]; // RULE15
         samp_b <= second_in[pair_sel]; // RULE15
      end
   end

   // presented results, first channel usable while second converts
   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         result_a <= '0;
         result_b <= '0;
         conv_count <= '0;
      end else if (CLK_EN) begin
         if (popped && !wq.out_data.chan_b) begin
            result_a <= wq.out_data.code; // RULE11
         end
         if (popped && wq.out_data.chan_b) begin
            result_b <= wq.out_data.code;
         end
         if (pair_done) begin
            conv_count <= conv_count + 1'b1;
         end
      end
   end

   // serial shifter on one data pin, order set by the channel pick
   logic [2*DATA_W-1:0] ser_sh;
   logic [5:0] ser_left;
   logic [CNT_W-1:0] ser_div;
   wire read_sel = ~sel_n & ~rd_n & ~conv_reset; // RULE5
   wire ser_load = popped & wq.out_data.chan_b;
   wire ser_step = read_sel & serial_style & (ser_left != '0)
      & (ser_div == '0);
   wire [2*DATA_W-1:0] ser_pair = pick_a ?
      {result_a, wq.out_data.code} : {wq.out_data.code, result_a}; // RULE6
   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         ser_sh <= '0;
         ser_left <= '0;
         ser_div <= '0;
      end else if (CLK_EN) begin
         if (ser_load) begin
            ser_sh <= ser_pair;
            ser_left <= SER_BITS;
            ser_div <= SER_LAST;
         end else if (ser_step) begin
            ser_sh <= {ser_sh[2*DATA_W-2:0], 1'b0};
            ser_left <= ser_left - 1'b1;
            ser_div <= SER_LAST;
         end else if (read_sel && ser_div != '0) begin
            ser_div <= ser_div - 1'b1;
         end
      end
   end

   // read port drive, independent of the power state
   logic [DATA_W-1:0] next_data;
   logic [DATA_W-1:0] next_oe_n;
   wire [DATA_W-1:0] par_word = pick_a ? result_a : result_b; // RULE17
   always_comb begin
      next_data = '0;
      next_oe_n = '1;
      if (read_sel && !serial_style) begin // RULE8 RULE10 RULE14
         next_data = par_word;
         next_oe_n = '0;
      end else if (read_sel && serial_style) begin // RULE9
         next_data[SER_OUT_PIN] = ser_sh[2*DATA_W-1];
         next_oe_n[SER_OUT_PIN] = 1'b0;
      end
   end

   // registered pin outputs
   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         DATA_OUT <= '0;
         DATA_OE_N <= '1;
         BUSY <= 1'b0;
         CHANNEL_CONVERTING <= 1'b0;
         LOW_POWER <= 1'b0;
      end else if (CLK_EN) begin
         DATA_OUT <= next_data;
         DATA_OE_N <= next_oe_n;
         BUSY <= (next_state == DSC_CONV_A)
            || (next_state == DSC_CONV_B); // RULE18
         CHANNEL_CONVERTING <= (next_state == DSC_CONV_A && next_cnt != '0)
            || (next_state == DSC_CONV_B && next_cnt != '0);
         LOW_POWER <= impulse && (next_state != DSC_CONV_A)
            && (next_state != DSC_CONV_B); // RULE13
      end
   end

   // bus address phase decode
   wire addr_ok = HSEL & HTRANS[1] & HREADY;
   wire [ADDR_W-1:0] a_addr = HADDR[ADDR_W-1:0];
   wire in_range = (HADDR[31:ADDR_W] == '0);
   logic wr_pend;
   logic [ADDR_W-1:0] wr_addr;
   wire ctrl_wr = wr_pend & (wr_addr == REG_CTRL);
   wire [1:0] ctrl_now = ctrl_wr ? HWDATA[1:0] : ctrl;
   wire [31:0] status_word = {20'h0, state, 4'h0, ~wq.in_ready,
      LOW_POWER, CHANNEL_CONVERTING, BUSY};
   wire [31:0] rd_word = !in_range ? 32'h0 :
      (a_addr == REG_CTRL) ? {30'h0, ctrl_now} :
      (a_addr == REG_STATUS) ? status_word :
      (a_addr == REG_RESULT) ? {result_b, result_a} :
      (a_addr == REG_COUNT) ? conv_count : 32'h0;

   // bus slave: zero wait states, write lands in the data phase
   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         wr_pend <= 1'b0;
         wr_addr <= '0;
         ctrl <= CTRL_RESET;
         HRDATA <= '0;
         HREADYOUT <= 1'b1;
         HRESP <= HRESP_OKAY;
      end else if (CLK_EN) begin
         wr_pend <= addr_ok & HWRITE & in_range;
         wr_addr <= a_addr;
         if (ctrl_wr) begin
            ctrl <= HWDATA[1:0];
         end
         HRDATA <= (addr_ok && !HWRITE) ? rd_word : 32'h0;
         HREADYOUT <= 1'b1;
         HRESP <= HRESP_OKAY;
      end
   end
endmodule

//--- bench/dsc_conv_port_assertions.sv
// checker: pin and bus timing relations of the conversion port
// assumes binding onto dsc_conv_port with all pins settled between edges
`timescale 1ns/100ps
module dsc_conv_port_assertions
   import dsc_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   input wire logic HSEL,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [31:0] HRDATA,
   input wire logic HREADYOUT,
   input wire logic HRESP,
   input wire logic CHIP_SELECT_N,
   input wire logic READ_ENABLE_N,
   input wire logic PORT_STYLE_SELECT,
   input wire logic CONVERTER_RESET,
   input wire logic BUSY,
   input wire logic CHANNEL_CONVERTING,
   input wire logic LOW_POWER,
   input wire logic [DATA_W-1:0] DATA_OE_N
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RESET_N);
   logic [7:0] run_len;
   logic [3:0] calm;
   logic par_on, ser_on;
   // busy run length and quiet time since the last converter reset
   always_ff @(posedge SYS_CLK) begin
      run_len <= (!RESET_N || !BUSY) ? 8'h0 : run_len + 8'h1;
      calm <= (!RESET_N || CONVERTER_RESET) ? 4'h0 :
         calm + {3'h0, calm != 4'hf};
   end
   // read port enabled in either style
   assign par_on = !CHIP_SELECT_N && !READ_ENABLE_N && !CONVERTER_RESET;
   assign ser_on = par_on && PORT_STYLE_SELECT;
   AST_OE_SEL: assert property (CHIP_SELECT_N [*5] |->
      DATA_OE_N == 16'hffff) else $error("bus driven while deselected");
   AST_OE_RD: assert property (READ_ENABLE_N [*5] |->
      DATA_OE_N == 16'hffff) else $error("bus driven without read");
   AST_ABORT: assert property (CONVERTER_RESET [*6] |->
      DATA_OE_N == 16'hffff && !BUSY) else $error("reset did not abort");
   AST_PAR: assert property ((par_on && !PORT_STYLE_SELECT) [*7] |->
      DATA_OE_N == 16'h0000) else $error("parallel bus not driven");
   AST_SER: assert property (ser_on [*7] |->
      (DATA_OE_N | (16'h1 << SER_OUT_PIN)) == 16'hffff)
      else $error("serial style drives a wrong pin");
   AST_BUSY_LEN: assert property ($fell(BUSY) && calm == 4'hf |->
      run_len >= 8'(2 * CONV_CYC) && run_len <= 8'(2 * CONV_CYC + 4))
      else $error("busy length off");
   AST_CONV_BUSY: assert property (CHANNEL_CONVERTING |-> BUSY)
      else $error("converting without busy");
   AST_LOW_PWR: assert property (
      CHANNEL_CONVERTING && $past(CHANNEL_CONVERTING) |-> !LOW_POWER)
      else $error("low power during conversion");
   AST_RD_IDLE: assert property (
      !$past(HSEL && HTRANS[1] && !HWRITE && HREADYOUT) |-> HRDATA == 32'h0)
      else $error("read data outside a data phase");
   AST_OKAY: assert property (HREADYOUT && !HRESP)
      else $error("bus not ready or not okay");
endmodule
bind dsc_conv_port dsc_conv_port_assertions chk_u (
   .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .HSEL(HSEL), .HTRANS(HTRANS),
   .HWRITE(HWRITE), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
   .CHIP_SELECT_N(CHIP_SELECT_N), .READ_ENABLE_N(READ_ENABLE_N),
   .PORT_STYLE_SELECT(PORT_STYLE_SELECT), .CONVERTER_RESET(CONVERTER_RESET),
   .BUSY(BUSY), .CHANNEL_CONVERTING(CHANNEL_CONVERTING),
   .LOW_POWER(LOW_POWER), .DATA_OE_N(DATA_OE_N)
);

//--- bench/dsc_host_model.sv
// host pin model: start strobe and pair choice of the controller
// assumes the bench asks for a launch with a one-cycle go pulse
`timescale 1ns/100ps
module dsc_host_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic go,
   input wire logic keep_low,
   input wire logic pair_req,
   input wire logic [3:0] lag,
   input wire logic busy,
   output logic convert_start_n,
   output logic input_pair_select
);
   logic armed;
   logic [4:0] left;
   // strobe after a chosen lag: two cycles low, or held low for free run
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         armed <= 1'b0;
         left <= 5'h0;
         convert_start_n <= 1'b1;
         input_pair_select <= 1'b0;
      end else if (go && !armed) begin
         armed <= 1'b1;
         left <= {1'b0, lag} + 5'h3;
         if (!busy)
            input_pair_select <= pair_req;
      end else if (armed) begin
         left <= left - 5'h1;
         if (left == 5'h2)
            convert_start_n <= 1'b0;
         if (left == 5'h0) begin
            convert_start_n <= !keep_low;
            armed <= 1'b0;
         end
      end else if (!keep_low) begin
         convert_start_n <= 1'b1;
      end
   end
endmodule

//--- bench/dsc_conv_port_bench.sv
// bench: register bus, conversions, read port, abort, impulse, buffer
// assumes the design files and the host model are compiled first
`timescale 1ns/100ps
module dsc_conv_port_bench;
   import dsc_pkg::*;
   logic sys_clk = 1'b0, reset_n = 1'b0, hwrite = 1'b0, cs_n = 1'b1;
   logic rd_n = 1'b1, pick = 1'b1, style = 1'b0, pd = 1'b0, go = 1'b0;
   logic conv_rst = 1'b0, keep_low = 1'b0, pair_req = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, got, exp_v;
   logic [1:0] htrans = HTRANS_IDLE, obs_sel = 2'h0;
   logic [3:0] lag = 4'h0;
   logic [1:0][DATA_W-1:0] first_in = '0, second_in = '0;
   logic [DATA_W-1:0] dout, oe_n, ser_hi;
   logic hreadyout, hresp, start_n, pair, busy, conv, low_pw;
   logic [31:0] exp_q[$];
   int bad_count = 0, checked = 0, pairs = 0, seed;
   // 125 MHz system clock
   always #4 sys_clk = ~sys_clk;
   dsc_conv_port dut_u (
      .SYS_CLK(sys_clk), .RESET_N(reset_n), .CLK_EN(1'b1), .HSEL(1'b1),
      .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
      .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
      .HREADYOUT(hreadyout), .HRESP(hresp), .CONVERT_START_N(start_n),
      .CHIP_SELECT_N(cs_n), .READ_ENABLE_N(rd_n), .CHANNEL_PICK(pick),
      .PORT_STYLE_SELECT(style), .INPUT_PAIR_SELECT(pair),
      .POWER_DOWN_INPUT(pd), .CONVERTER_RESET(conv_rst),
      .FIRST_CHANNEL_INPUT(first_in), .SECOND_CHANNEL_INPUT(second_in),
      .BUSY(busy), .CHANNEL_CONVERTING(conv), .LOW_POWER(low_pw),
      .DATA_OUT(dout), .DATA_OE_N(oe_n));
   dsc_host_model host_u (
      .clk(sys_clk), .rst_n(reset_n), .go(go), .keep_low(keep_low),
      .pair_req(pair_req), .lag(lag), .busy(busy),
      .convert_start_n(start_n), .input_pair_select(pair));
   // monitor: oldest note against the watched result
   always @(posedge sys_clk) begin
      if (obs_sel != 2'h0 && hreadyout === 1'b1) begin
         case (obs_sel)
            2'h1: got = hrdata;
            2'h2: got = {oe_n, dout};
            default: got = {29'h0, busy, low_pw, conv};
         endcase
         exp_v = exp_q.pop_front();
         checked++;
         if (got !== exp_v) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp_v);
         end
      end
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic timeout();
      bad_count++;
      $display("[ERR] %0t wait ran out", $time);
      end_sim();
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic hold_rdy();
      int n;
      n = 0;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 20) timeout();
         @(posedge sys_clk);
      end
   endtask
   // one single word transfer; for a read d is the expected value
   task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      hold_rdy();
      htrans <= HTRANS_IDLE;
      hwdata <= wr ? d : 32'h0;
      if (!wr) exp_q.push_back(d);
      obs_sel <= wr ? 2'h0 : 2'h1;
      hold_rdy();
      obs_sel <= 2'h0;
   endtask
   task automatic look(input logic [1:0] sel, input logic [31:0] e);
      exp_q.push_back(e);
      obs_sel <= sel;
      tick(1);
      obs_sel <= 2'h0;
   endtask
   task automatic pins(input logic pk, input logic [15:0] e);
      pick <= pk;
      cs_n <= 1'b0;
      rd_n <= 1'b0;
      tick(5);
      look(2'h2, {16'h0, e});
   endtask
   task automatic await(input logic lvl, input int lim);
      int n;
      n = 0;
      while (busy !== lvl) begin
         @(posedge sys_clk);
         n++;
         if (n > lim) timeout();
      end
   endtask
   task automatic launch(input logic p);
      first_in <= {16'($urandom), 16'($urandom)};
      second_in <= {16'($urandom), 16'($urandom)};
      lag <= 4'($urandom_range(15));
      pair_req <= p;
      go <= 1'b1;
      tick(1);
      go <= 1'b0;
      await(1'b1, 40);
   endtask
   // main sequence
   initial begin
      seed = $urandom(63146);
      tick(5);
      reset_n <= 1'b1;
      tick(4);
      bus(1'b0, REG_CTRL, 32'h0);
      bus(1'b0, REG_COUNT, 32'h0);
      bus(1'b1, REG_STATUS, 32'hffffffff);
      bus(1'b1, 8'h40, 32'h3);
      bus(1'b0, 8'h40, 32'h0);
      bus(1'b1, REG_CTRL, 32'h3);
      bus(1'b0, REG_CTRL, 32'h3);
      bus(1'b1, REG_CTRL, 32'h0);
      // low-power flag trails the control write by one edge
      tick(1);
      bus(1'b0, REG_STATUS, 32'h1 << ST_STATE);
      // both pairs, with a restrike and power-down inside the conversion
      for (int p = 0; p < 2; p++) begin
         launch(p[0]);
         tick(20);
         go <= 1'b1;
         pd <= 1'b1;
         tick(1);
         go <= 1'b0;
         await(1'b0, 200);
         pd <= 1'b0;
         pairs++;
         tick(4);
         bus(1'b0, REG_RESULT, {second_in[p], first_in[p]});
         bus(1'b0, REG_COUNT, 32'(pairs));
         pins(1'b1, first_in[p]);
         pins(1'b0, second_in[p]);
         cs_n <= 1'b1;
         rd_n <= 1'b1;
      end
      // converter reset in mid-conversion drops the pair
      ser_hi = second_in[1];
      launch(1'b0);
      tick(30);
      conv_rst <= 1'b1;
      tick(8);
      look(2'h3, 32'h0);
      conv_rst <= 1'b0;
      tick(4);
      bus(1'b0, REG_COUNT, 32'(pairs));
      // serial: pick was low at load, second channel first, one bit gone
      style <= 1'b1;
      cs_n <= 1'b0;
      rd_n <= 1'b0;
      tick(5);
      look(2'h2, {~(16'h1 << SER_OUT_PIN),
         16'(ser_hi[14]) << SER_OUT_PIN});
      style <= 1'b0;
      // impulse free run with reads in acquisition, then normal mode
      bus(1'b1, REG_CTRL, 32'h1);
      keep_low <= 1'b1;
      launch(1'b1);
      for (int i = 0; i < 2; i++) begin
         await(1'b0, 200);
         tick(5);
         look(2'h3, 32'h2);
         pins(1'b1, first_in[1]);
         first_in[1] <= 16'($urandom);
         await(1'b1, SAMPLE_CYC);
         // read in the first half of the second channel's phase
         tick(CONV_CYC + CONV_CYC / 2 - 5);
         look(2'h2, {16'h0, first_in[1]});
      end
      bus(1'b1, REG_CTRL, 32'h0);
      await(1'b0, 200);
      tick(200);
      look(2'h3, 32'h0);
      keep_low <= 1'b0;
      cs_n <= 1'b1;
      // output stage held: buffer fills and the next launch waits
      bus(1'b1, REG_CTRL, 32'h2);
      launch(1'b0);
      await(1'b0, 200);
      tick(4);
      bus(1'b0, REG_STATUS, (32'h1 << ST_STATE) | (32'h1 << ST_BUF_FULL));
      first_in[0] <= 16'($urandom);
      go <= 1'b1;
      tick(1);
      go <= 1'b0;
      tick(40);
      look(2'h3, 32'h0);
      bus(1'b1, REG_CTRL, 32'h0);
      await(1'b1, 40);
      await(1'b0, 200);
      tick(4);
      bus(1'b0, REG_RESULT, {second_in[0], first_in[0]});
      bus(1'b0, REG_STATUS, 32'h1 << ST_STATE);
      end_sim();
   end
endmodule
